// File: verilog/cdi_device.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Answer only slave address 0111110.
// - Master always sends write direction bit.
// - Only the acknowledge is driven onto SDA.
// - SDA falling with SCL high starts.
// - SDA rising with SCL high stops.
// - SDA stable while SCL high.
// - Hold SDA low through ninth pulse.
// - Mismatch: ignore everything until next start.
// - Acknowledge every byte after address match.
// - Words are control byte then data byte.
// - Cleared continuation: rest are data bytes.
// - Select high: bytes go to RAM.
// - Select low: bytes executed as instructions.
// - Acknowledge ignores internal busy state.
// - Data write transfers into selected RAM.
// - Parallel data read reloads next address.
// - Instruction register is never readable.
// - Instructions refused while busy flag high.
// - Status read: busy bit seven, pointer below.
// - Pointer loaded by instruction, steps by one.
// - Text RAM holds eighty bytes.
// - Width select picks 4-bit or 8-bit bus.
// - Two-line: 00-27 then 40-67.
module cdi_device
  import cdi_pkg::*;
(
  // Clocks and reset
  input  wire logic       clk_sys_in,
  input  wire logic       clk_link_in,
  input  wire logic       reset_in,
  // Parallel host port, synchronous to clk_sys_in
  input  wire logic       par_strobe_in,
  input  wire logic       par_rw_in,
  input  wire logic       reg_select_in,
  input  wire logic [7:0] par_data_in,
  output logic      [7:0] par_data_out,
  // Status and display readout
  output logic            internal_op_flag_out,
  output logic            bus_width_select_out,
  output logic            two_line_out,
  input  wire logic [6:0] disp_addr_in,
  output logic      [7:0] disp_data_out,
  // Serial link
  cdi_link_if.device      link
);
  typedef struct packed {
    cdi_link_st_t st;
    logic         scl_m, scl_s, scl_p;
    logic         sda_m, sda_s, sda_p;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic         ack_pend;
    logic         sda_oe;
    logic         rs_hold;
    logic [7:0]   rx_byte;
    logic         rx_rs;
    logic         ev_tgl;
  } cdi_link_t;

  typedef struct packed {
    logic [TEXT_DEPTH-1:0][7:0]  text_ram;
    logic [GLYPH_DEPTH-1:0][7:0] glyph_ram;
    logic [SYM_DEPTH-1:0][7:0]   symbol_ram;
    logic [7:0]   command_holding;
    logic [7:0]   write_holding;
    logic [6:0]   ram_pointer;
    cdi_target_t  tgt;
    logic         incr;
    logic         two_line;
    logic         bus_width_select;
    logic         is_ext;
    logic [7:0]   busy_cnt;
    logic         internal_op_flag;
    logic [2:0]   ev_sync;
    logic         nib_phase;
    logic [7:0]   nib_buf;
    logic [7:0]   pdata;
    logic [7:0]   disp;
  } cdi_sys_t;

  cdi_link_t l_reg, l_next;
  cdi_sys_t  s_reg, s_next;
  logic [1:0] lrst_pipe_reg;

  // ==========================================================
  // Address helpers
  function automatic logic [6:0] text_slot(input logic [6:0] p, input logic two);
    if (!two) begin
      text_slot = (p <= ONE_LINE_LAST) ? p : NO_SLOT;
    end else if (p >= LINE2_FIRST) begin
      text_slot = (p <= LINE2_LAST) ? 7'(p - LINE2_FIRST + LINE1_LAST + 7'h01) : NO_SLOT;
    end else begin
      text_slot = (p <= LINE1_LAST) ? p : NO_SLOT;
    end
  endfunction

  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic inc,
                                          input logic two, input cdi_target_t t);
    logic [6:0] q;
    q = inc ? 7'(p + 7'h01) : 7'(p - 7'h01);
    unique case (t)
      TGT_TEXT: begin
        if (two && inc && p == LINE1_LAST)          q = LINE2_FIRST;
        else if (two && inc && p == LINE2_LAST)     q = 7'h00;
        else if (two && !inc && p == LINE2_FIRST)   q = LINE1_LAST;
        else if (two && !inc && p == 7'h00)         q = LINE2_LAST;
        else if (!two && inc && p == ONE_LINE_LAST) q = 7'h00;
        else if (!two && !inc && p == 7'h00)        q = ONE_LINE_LAST;
      end
      TGT_GLYPH: q = {1'h0, q[5:0]};
      TGT_SYM:   q = {3'h0, q[3:0]};
      default:   q = p;
    endcase
    step_ptr = q;
  endfunction

  function automatic logic [7:0] ram_read(input cdi_sys_t s, input logic [6:0] p);
    logic [6:0] k;
    k = text_slot(p, s.two_line);
    unique case (s.tgt)
      TGT_TEXT:  ram_read = (k < 7'(TEXT_DEPTH)) ? s.text_ram[k] : 8'h00;
      TGT_GLYPH: ram_read = s.glyph_ram[p[5:0]];
      TGT_SYM:   ram_read = s.symbol_ram[p[3:0]];
      default:   ram_read = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Link side, on the link clock
  logic       rise, fall, start_c, stop_c;
  logic [7:0] byte_c;

  always_comb begin
    l_next       = l_reg;
    l_next.scl_m = link.scl;
    l_next.scl_s = l_reg.scl_m;
    l_next.scl_p = l_reg.scl_s;
    l_next.sda_m = link.sda;
    l_next.sda_s = l_reg.sda_m;
    l_next.sda_p = l_reg.sda_s;
    rise    = l_reg.scl_s & ~l_reg.scl_p;
    fall    = ~l_reg.scl_s & l_reg.scl_p;
    start_c = l_reg.scl_s & l_reg.scl_p & l_reg.sda_p & ~l_reg.sda_s;
    stop_c  = l_reg.scl_s & l_reg.scl_p & ~l_reg.sda_p & l_reg.sda_s;
    byte_c  = {l_reg.shift[6:0], l_reg.sda_s};
    if (start_c) begin
      l_next.st      = LK_ADDR;
      l_next.bit_cnt = 4'h0;
      l_next.sda_oe  = 1'h0;
    end else if (stop_c) begin
      l_next.st     = LK_IDLE;
      l_next.sda_oe = 1'h0;
    end else if (l_reg.st != LK_IDLE && l_reg.st != LK_IGNORE) begin
      if (rise && l_reg.bit_cnt < BYTE_BITS) begin
        l_next.shift   = byte_c;
        l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
        if (l_reg.bit_cnt == BYTE_BITS - 4'h1) begin
          // Acknowledge is armed without looking at the busy flag
          l_next.ack_pend = 1'h1;
          unique case (l_reg.st)
            LK_ADDR: begin
              if (byte_c[7:1] != SLAVE_ADDR || byte_c[0] != RW_WRITE) begin
                l_next.ack_pend = 1'h0;
                l_next.st       = LK_IGNORE;
              end else begin
                l_next.st = LK_CTRL;
              end
            end
            LK_CTRL: begin
              l_next.rs_hold = byte_c[RS_BIT];
              l_next.st      = byte_c[CO_BIT] ? LK_DATA : LK_STREAM;
            end
            default: begin
              l_next.rx_byte = byte_c;
              l_next.rx_rs   = l_reg.rs_hold;
              l_next.ev_tgl  = ~l_reg.ev_tgl;
              if (l_reg.st == LK_DATA) begin
                l_next.st = LK_CTRL;
              end
            end
          endcase
        end
      end else if (fall && l_reg.bit_cnt == BYTE_BITS) begin
        l_next.sda_oe   = l_reg.ack_pend;
        l_next.ack_pend = 1'h0;
        l_next.bit_cnt  = ACK_SLOT;
      end else if (fall && l_reg.bit_cnt == ACK_SLOT) begin
        l_next.sda_oe  = 1'h0;
        l_next.bit_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_link_in) begin
    lrst_pipe_reg <= {lrst_pipe_reg[0], reset_in};
  end

  always_ff @(posedge clk_link_in) begin
    if (lrst_pipe_reg[1]) begin
      l_reg       <= '0;
      l_reg.st    <= LK_IDLE;
      l_reg.scl_m <= 1'h1;
      l_reg.scl_s <= 1'h1;
      l_reg.scl_p <= 1'h1;
      l_reg.sda_m <= 1'h1;
      l_reg.sda_s <= 1'h1;
      l_reg.sda_p <= 1'h1;
    end else begin
      l_reg <= l_next;
    end
  end

  // ==========================================================
  // Core side, on the system clock
  logic       ev, wr_go, wr_rs, rd_go, rd_first;
  logic [7:0] wr_byte, rd_val;
  logic [6:0] slot;

  always_comb begin
    s_next         = s_reg;
    s_next.ev_sync = {s_reg.ev_sync[1:0], l_reg.ev_tgl};
    ev             = s_reg.ev_sync[2] ^ s_reg.ev_sync[1];
    if (s_reg.busy_cnt != 8'h00) begin
      s_next.busy_cnt = s_reg.busy_cnt - 8'h01;
    end
    slot        = text_slot(disp_addr_in, s_reg.two_line);
    s_next.disp = (slot < 7'(TEXT_DEPTH)) ? s_reg.text_ram[slot] : 8'h00;
    wr_go    = 1'h0;
    wr_rs    = 1'h0;
    wr_byte  = 8'h00;
    rd_go    = 1'h0;
    rd_first = 1'h1;
    rd_val   = 8'h00;
    // Held link data is stable for a whole byte time after the toggle
    if (ev) begin
      wr_go   = 1'h1;
      wr_rs   = l_reg.rx_rs;
      wr_byte = l_reg.rx_byte;
    end else if (par_strobe_in) begin
      if (!s_reg.bus_width_select) begin
        s_next.nib_phase = ~s_reg.nib_phase;
        rd_first         = ~s_reg.nib_phase;
      end
      if (par_rw_in) begin
        rd_go = rd_first;
        if (!rd_first) begin
          s_next.pdata = {s_reg.nib_buf[3:0], 4'h0};
        end
      end else if (s_reg.bus_width_select || s_reg.nib_phase) begin
        wr_go   = 1'h1;
        wr_rs   = reg_select_in;
        wr_byte = s_reg.bus_width_select ? par_data_in
                                         : {s_reg.nib_buf[7:4], par_data_in[7:4]};
      end else begin
        s_next.nib_buf = par_data_in;
      end
    end
    if (rd_go) begin
      // Only status or data can be read back, never the instruction
      rd_val         = reg_select_in ? s_reg.write_holding
                                     : {s_reg.internal_op_flag, s_reg.ram_pointer};
      s_next.pdata   = rd_val;
      s_next.nib_buf = rd_val;
      if (reg_select_in) begin
        s_next.ram_pointer   = step_ptr(s_reg.ram_pointer, s_reg.incr,
                                        s_reg.two_line, s_reg.tgt);
        s_next.write_holding = ram_read(s_reg, s_next.ram_pointer);
      end
    end
    if (wr_go && wr_rs) begin
      s_next.write_holding = wr_byte;
      slot = text_slot(s_reg.ram_pointer, s_reg.two_line);
      unique case (s_reg.tgt)
        TGT_TEXT: begin
          if (slot < 7'(TEXT_DEPTH)) begin
            s_next.text_ram[slot] = wr_byte;
          end
        end
        TGT_GLYPH: s_next.glyph_ram[s_reg.ram_pointer[5:0]]  = wr_byte;
        TGT_SYM:   s_next.symbol_ram[s_reg.ram_pointer[3:0]] = wr_byte;
        default: ;
      endcase
      s_next.ram_pointer = step_ptr(s_reg.ram_pointer, s_reg.incr,
                                    s_reg.two_line, s_reg.tgt);
    end else if (wr_go && !s_reg.internal_op_flag) begin
      s_next.command_holding = wr_byte;
      s_next.busy_cnt        = 8'(OP_CYCLES);
      priority casez (wr_byte)
        PAT_CLEAR: begin
          for (int i = 0; i < TEXT_DEPTH; i++) begin
            s_next.text_ram[i] = BLANK_CHAR;
          end
          s_next.ram_pointer = 7'h00;
          s_next.incr        = 1'h1;
          s_next.tgt         = TGT_TEXT;
        end
        PAT_HOME: begin
          s_next.ram_pointer = 7'h00;
          s_next.tgt         = TGT_TEXT;
        end
        PAT_ENTRY: s_next.incr = wr_byte[ID_BIT];
        PAT_FSET: begin
          s_next.bus_width_select = wr_byte[DL_BIT];
          s_next.two_line         = wr_byte[N_BIT];
          s_next.is_ext           = wr_byte[IS_BIT];
        end
        PAT_TEXT: begin
          s_next.tgt         = TGT_TEXT;
          s_next.ram_pointer = wr_byte[6:0];
        end
        PAT_SYM, PAT_GLYPH: begin
          if (s_reg.is_ext && wr_byte[5:4] == 2'h0) begin
            s_next.tgt         = TGT_SYM;
            s_next.ram_pointer = {3'h0, wr_byte[3:0]};
          end else if (!s_reg.is_ext) begin
            s_next.tgt         = TGT_GLYPH;
            s_next.ram_pointer = {1'h0, wr_byte[5:0]};
          end
        end
        default: ;
      endcase
      s_next.write_holding = ram_read(s_next, s_next.ram_pointer);
    end
    s_next.internal_op_flag = (s_next.busy_cnt != 8'h00);
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_reg                  <= '0;
      s_reg.tgt              <= TGT_TEXT;
      s_reg.incr             <= 1'h1;
      s_reg.bus_width_select <= 1'h1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.dev_sda_oe      = l_reg.sda_oe;
  assign par_data_out         = s_reg.pdata;
  assign internal_op_flag_out = s_reg.internal_op_flag;
  assign bus_width_select_out = s_reg.bus_width_select;
  assign two_line_out         = s_reg.two_line;
  assign disp_data_out        = s_reg.disp;
endmodule
`default_nettype wire

// File: verilog/cdi_pkg.sv
package cdi_pkg;
  // Serial link
  localparam logic [6:0] SLAVE_ADDR    = 7'h3E;
  localparam logic       RW_WRITE      = 1'h0;
  localparam int         CO_BIT        = 7;
  localparam int         RS_BIT        = 6;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] ACK_SLOT      = 4'h9;
  // Memories
  localparam int         TEXT_DEPTH    = 80;
  localparam int         GLYPH_DEPTH   = 64;
  localparam int         SYM_DEPTH     = 16;
  localparam logic [6:0] LINE1_LAST    = 7'h27;
  localparam logic [6:0] LINE2_FIRST   = 7'h40;
  localparam logic [6:0] LINE2_LAST    = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  localparam logic [6:0] NO_SLOT       = 7'h7F;
  localparam logic [7:0] BLANK_CHAR    = 8'h20;
  // Instruction encodings and fields
  localparam logic [7:0] PAT_CLEAR     = 8'b0000_0001;
  localparam logic [7:0] PAT_HOME      = 8'b0000_001?;
  localparam logic [7:0] PAT_ENTRY     = 8'b0000_01??;
  localparam logic [7:0] PAT_FSET      = 8'b001?_????;
  localparam logic [7:0] PAT_SYM       = 8'b0100_????;
  localparam logic [7:0] PAT_GLYPH     = 8'b01??_????;
  localparam logic [7:0] PAT_TEXT      = 8'b1???_????;
  localparam int         ID_BIT        = 1;
  localparam int         DL_BIT        = 4;
  localparam int         N_BIT         = 3;
  localparam int         IS_BIT        = 0;
  // Timing
  localparam int         SYS_CLK_HZ    = 10_000_000;
  localparam int         OP_TIME_NS    = 1000;
  localparam int         OP_CYCLES     = (OP_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int         SCL_HZ        = 100_000;
  localparam int         SCL_HALF      = SYS_CLK_HZ / (2 * SCL_HZ);

  typedef enum logic [1:0] {TGT_TEXT, TGT_GLYPH, TGT_SYM} cdi_target_t;
  typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_CTRL, LK_DATA, LK_STREAM, LK_IGNORE} cdi_link_st_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_XFER, H_WAIT, H_STOP} cdi_host_st_t;
endpackage

// File: verilog/cdi_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cdi_link_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;

  // Open-drain data line with pull-up
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport device (input scl, input sda, output dev_sda_oe);
  modport host (output scl, output host_sda_oe, input sda);
endinterface
`default_nettype wire

// File: verilog/cdi_host.sv
`timescale 1ns/10ps
`default_nettype none
module cdi_host
  import cdi_pkg::*;
#(
  parameter int HALF = SCL_HALF
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // Byte source
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_stop_in,
  output logic            tx_ready_out,
  output logic            nack_out,
  output logic            busy_out,
  // Link
  cdi_link_if.host        link
);
  typedef struct packed {
    cdi_host_st_t st;
    logic [15:0]  cnt;
    logic [3:0]   bit_n;
    logic [7:0]   shift;
    logic [7:0]   pend;
    logic         pend_stop;
    logic         stop_cur;
    logic         is_addr;
    logic         scl;
    logic         sda_oe;
    logic         ready;
    logic         nack;
    logic         sda_m;
    logic         sda_s;
    logic         busy;
  } cdi_host_t;

  cdi_host_t h_reg, h_next;

  // ==========================================================
  // Sequencer
  always_comb begin
    h_next       = h_reg;
    h_next.sda_m = link.sda;
    h_next.sda_s = h_reg.sda_m;
    h_next.cnt   = h_reg.cnt + 16'h0001;
    unique case (h_reg.st)
      H_IDLE: begin
        h_next.scl   = 1'h1;
        h_next.ready = 1'h1;
        if (tx_valid_in && h_reg.ready) begin
          h_next.pend      = tx_byte_in;
          h_next.pend_stop = tx_stop_in;
          h_next.sda_oe    = 1'h1;
          h_next.ready     = 1'h0;
          h_next.nack      = 1'h0;
          h_next.cnt       = 16'h0000;
          h_next.st        = H_START;
        end
      end
      H_START: begin
        if (h_reg.cnt == 16'(HALF - 1)) begin
          h_next.scl     = 1'h0;
          h_next.shift   = {SLAVE_ADDR, RW_WRITE};
          h_next.is_addr = 1'h1;
          h_next.bit_n   = 4'h0;
          h_next.cnt     = 16'h0000;
          h_next.st      = H_XFER;
        end
      end
      H_XFER: begin
        if (h_reg.cnt == 16'h0000) begin
          h_next.sda_oe = (h_reg.bit_n < BYTE_BITS) ? ~h_reg.shift[7] : 1'h0;
        end
        if (h_reg.cnt == 16'(HALF)) begin
          h_next.scl = 1'h1;
        end
        if (h_reg.cnt == 16'(HALF + HALF / 2) && h_reg.bit_n == BYTE_BITS) begin
          h_next.nack = h_reg.sda_s;
        end
        if (h_reg.cnt == 16'(2 * HALF - 1)) begin
          h_next.scl = 1'h0;
          h_next.cnt = 16'h0000;
          if (h_reg.bit_n < BYTE_BITS) begin
            h_next.shift = {h_reg.shift[6:0], 1'h0};
            h_next.bit_n = h_reg.bit_n + 4'h1;
          end else if (h_reg.nack) begin
            h_next.st = H_STOP;
          end else if (h_reg.is_addr) begin
            h_next.shift    = h_reg.pend;
            h_next.stop_cur = h_reg.pend_stop;
            h_next.is_addr  = 1'h0;
            h_next.bit_n    = 4'h0;
          end else if (h_reg.stop_cur) begin
            h_next.st = H_STOP;
          end else begin
            h_next.ready = 1'h1;
            h_next.st    = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        if (tx_valid_in && h_reg.ready) begin
          h_next.shift    = tx_byte_in;
          h_next.stop_cur = tx_stop_in;
          h_next.bit_n    = 4'h0;
          h_next.cnt      = 16'h0000;
          h_next.ready    = 1'h0;
          h_next.st       = H_XFER;
        end
      end
      H_STOP: begin
        if (h_reg.cnt == 16'h0000) begin
          h_next.sda_oe = 1'h1;
        end
        if (h_reg.cnt == 16'(HALF)) begin
          h_next.scl = 1'h1;
        end
        if (h_reg.cnt == 16'(2 * HALF)) begin
          h_next.sda_oe = 1'h0;
        end
        if (h_reg.cnt == 16'(3 * HALF - 1)) begin
          h_next.st = H_IDLE;
        end
      end
    endcase
    // Busy is registered with the rest so that it stays a direct flop output
    h_next.busy = (h_next.st != H_IDLE);
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      h_reg       <= '0;
      h_reg.st    <= H_IDLE;
      h_reg.scl   <= 1'h1;
      h_reg.sda_m <= 1'h1;
      h_reg.sda_s <= 1'h1;
    end else begin
      h_reg <= h_next;
    end
  end

  assign link.scl         = h_reg.scl;
  assign link.host_sda_oe = h_reg.sda_oe;
  assign tx_ready_out     = h_reg.ready;
  assign nack_out         = h_reg.nack;
  assign busy_out         = h_reg.busy;
endmodule
`default_nettype wire

// File: testbench/cdi_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cdi_link_assertions
  import cdi_pkg::*;
(
  // Link domain
  input wire logic clk_link_in,
  input wire logic reset_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  logic       scl_q, sda_q, first, match, frame;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire rise  = scl & ~scl_q;
  wire fall  = ~scl & scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop  = scl & scl_q & ~sda_q & sda;
  wire due   = first ? (sh == {SLAVE_ADDR, RW_WRITE}) : match;
  // ===========================================
  // Frame tracker
  always_ff @(posedge clk_link_in) begin
    scl_q <= scl;
    sda_q <= sda;
    if (reset_in) begin
      frame <= 1'h0;
      cnt   <= 4'h0;
      first <= 1'h0;
      match <= 1'h0;
    end else if (start) begin
      frame <= 1'h1;
      cnt   <= 4'h0;
      first <= 1'h1;
      match <= 1'h0;
    end else if (stop) begin
      frame <= 1'h0;
    end else if (rise) begin
      cnt <= cnt + 4'h1;
      if (cnt < 4'h8) begin
        sh <= {sh[6:0], sda};
      end
    end else if (fall && cnt == 4'h9) begin
      cnt   <= 4'h0;
      first <= 1'h0;
      match <= due;
    end
  end
  // ===========================================
  // Properties
  default clocking @(posedge clk_link_in); endclocking
  default disable iff (reset_in);
  property p_only_ack; $rose(dev_sda_oe) |-> cnt == 4'h8; endproperty
  a_only_ack: assert property (p_only_ack) else $error("drive outside ack slot");
  property p_ack_rise; fall && cnt == 4'h8 && due && frame |-> ##[1:8] dev_sda_oe; endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack not driven");
  property p_ack_slot; rise && cnt == 4'h8 && due |-> dev_sda_oe; endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack missing at pulse");
  property p_no_ack; rise && cnt == 4'h8 && !due |-> !dev_sda_oe; endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack when ignored");
  property p_hold; $fell(dev_sda_oe) |-> !scl; endproperty
  a_hold: assert property (p_hold) else $error("ack dropped in high phase");
  property p_no_cond; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  a_no_cond: assert property (p_no_cond) else $error("device made condition");
  property p_release; fall && cnt == 4'h9 |-> ##[1:8] !dev_sda_oe; endproperty
  a_release: assert property (p_release) else $error("ack not released");
  property p_idle; !frame |-> !dev_sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("drive outside frame");
endmodule
`default_nettype wire

// File: testbench/char_display_i2c_write_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module char_display_i2c_write_port_tb_top;
  import cdi_pkg::*;
  logic       clk_sys_in = 0, clk_link_in = 0, reset_in = 1;
  logic       tv = 0, ts = 0, stb = 0, rw = 0, rs = 0, sclb = 1, oeb = 0;
  logic [7:0] tby = 0, pd = 0;
  logic [6:0] da = 0;
  wire        rdy, nack, busy, flag, width, two;
  wire  [7:0] pq, dq;
  int         errors = 0, compares = 0;
  cdi_link_if i_cdi_link_if ();
  cdi_link_if i_cdi_link_if_b ();
  assign i_cdi_link_if_b.scl = sclb;
  assign i_cdi_link_if_b.host_sda_oe = oeb;
  cdi_host #(.HALF(8)) i_cdi_host (.clk_sys_in, .reset_in, .tx_valid_in(tv),
    .tx_byte_in(tby), .tx_stop_in(ts), .tx_ready_out(rdy), .nack_out(nack),
    .busy_out(busy), .link(i_cdi_link_if.host));
  cdi_device i_cdi_device (.clk_sys_in, .clk_link_in, .reset_in, .par_strobe_in(stb),
    .par_rw_in(rw), .reg_select_in(rs), .par_data_in(pd), .par_data_out(pq),
    .internal_op_flag_out(flag), .bus_width_select_out(width), .two_line_out(two),
    .disp_addr_in(da), .disp_data_out(dq), .link(i_cdi_link_if.device));
  cdi_device i_cdi_device_b (.clk_sys_in, .clk_link_in, .reset_in, .par_strobe_in(stb),
    .par_rw_in(rw), .reg_select_in(rs), .par_data_in(pd), .par_data_out(),
    .internal_op_flag_out(), .bus_width_select_out(), .two_line_out(),
    .disp_addr_in(da), .disp_data_out(), .link(i_cdi_link_if_b.device));
  cdi_link_assertions i_cdi_link_assertions (.clk_link_in, .reset_in,
    .scl(i_cdi_link_if.scl), .sda(i_cdi_link_if.sda), .dev_sda_oe(i_cdi_link_if.dev_sda_oe));
  always #50 clk_sys_in = ~clk_sys_in;
  always #16 clk_link_in = ~clk_link_in;
  // ===========================================
  // Helpers
  task conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task send(input logic [7:0] b, input logic s);
    int n;
    tick(1);
    tv = 1;
    tby = b;
    ts = s;
    for (n = 0; n < 500 && rdy !== 1'b1; n++) tick(1);
    if (n == 500) begin
      errors++;
      conclude();
    end
    tick(1);
    tv = 0;
  endtask
  task idle;
    int n;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) tick(1);
    if (n == 3000) begin
      errors++;
      conclude();
    end
    tick(20);
  endtask
  task peek(input logic [6:0] a, input logic [7:0] e);
    da = a;
    tick(2);
    check(dq, e);
  endtask
  task par(input logic r, input logic s, input logic [7:0] d);
    stb = 1;
    rw = r;
    rs = s;
    pd = d;
    tick(1);
    stb = 0;
    tick(1);
  endtask
  task rd(input logic s, input logic [7:0] e);
    par(1, s, 8'h00);
    check(pq, e);
  endtask
  task bstart;
    tick(8);
    oeb = 1;
    tick(8);
    sclb = 0;
    tick(4);
  endtask
  task bstop;
    oeb = 1;
    tick(4);
    sclb = 1;
    tick(8);
    oeb = 0;
    tick(8);
  endtask
  task bbyte(input logic [7:0] b, input logic exp);
    for (int i = 7; i >= 0; i--) begin
      oeb = ~b[i];
      tick(4);
      sclb = 1;
      tick(8);
      sclb = 0;
      tick(4);
    end
    oeb = 0;
    tick(4);
    sclb = 1;
    tick(4);
    check({7'h00, ~i_cdi_link_if_b.sda}, {7'h00, exp});
    tick(4);
    sclb = 0;
    tick(4);
  endtask
  // ===========================================
  // Sequence
  initial begin
    tick(20);
    reset_in = 0;
    tick(5);
    send(8'h80, 0);
    send(8'h80, 0);
    send(8'h40, 0);
    send(8'h41, 0);
    send(8'h80, 0);
    send(8'h42, 1);
    idle();
    check({7'h00, nack}, 8'h00);
    peek(7'h00, 8'h41);
    peek(7'h01, 8'h80);
    peek(7'h02, 8'h42);
    send(8'h00, 0);
    send(8'h38, 1);
    idle();
    check({7'h00, two}, 8'h01);
    par(0, 0, 8'hA7);
    check({7'h00, flag}, 8'h01);
    rd(0, 8'hA7);
    par(0, 0, 8'h80);
    tick(12);
    rd(0, 8'h27);
    par(0, 1, 8'h77);
    par(0, 1, 8'h66);
    rd(0, 8'h41);
    peek(7'h27, 8'h77);
    par(0, 0, 8'hA7);
    tick(12);
    rd(1, 8'h77);
    rd(1, 8'h66);
    par(0, 0, 8'h28);
    tick(12);
    check({7'h00, width}, 8'h00);
    par(0, 0, 8'h90);
    par(0, 0, 8'hA0);
    tick(12);
    rd(0, 8'h1A);
    rd(0, 8'hA0);
    bstart();
    bbyte(8'h7E, 0);
    bbyte(8'h80, 0);
    bstop();
    bstart();
    bbyte(8'h7D, 0);
    bstop();
    bstart();
    bbyte(8'h7C, 1);
    bbyte(8'h40, 1);
    bstop();
    conclude();
  end
endmodule
`default_nettype wire
